//--- core/lrr_loop_node.sv
`timescale 1ns/1ps
module lrr_loop_node (
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire logic                   rx_bit_valid,
  input  wire logic                   rx_bit,
  input  wire logic                   rx_sync,
  input  wire lrr_pkg::lrr_link_type  link,
  input  wire logic                   aa_echo,
  input  wire logic                   own_valid,
  input  wire lrr_pkg::lrr_frame_type own_frame,
  input  wire logic                   acc_valid,
  input  wire lrr_pkg::lrr_frame_type acc_frame,
  input  wire logic                   attention_bit,
  input  wire logic                   poll_en,
  input  wire logic [2:0]             poll_sel,
  input  wire logic                   poll_val,
  input  wire logic                   hold_ready,
  input  wire logic                   tx_bit_ready,
  output logic                        hold_valid,
  output lrr_pkg::lrr_frame_type      hold_frame,
  output logic                        own_taken,
  output logic                        acc_taken,
  output logic                        tx_bit,
  output logic                        tx_bit_valid,
  output logic                        tx_sync,
  output logic                        tx_done,
  output lrr_pkg::lrr_status_type     status
);

  typedef struct packed {
    lrr_pkg::lrr_rx_state_type rx_st;
    lrr_pkg::lrr_frame_type    rx_frm;
    logic [3:0]                rx_cnt;
    logic                      rx_is_cmd;
    lrr_pkg::lrr_tx_state_type tx_st;
    lrr_pkg::lrr_frame_type    tx_sh;
    logic [3:0]                tx_cnt;
    logic                      tx_valid;
    logic                      tx_bit;
    logic                      tx_sync;
    logic                      tx_done;
    logic                      own_taken;
    logic                      acc_taken;
    lrr_pkg::lrr_status_type   stat;
  } lrr_node_state_type;

  lrr_node_state_type s_q;
  lrr_node_state_type s_d;

  logic                   buf_in_valid;
  logic                   buf_in_ready;
  logic [10:0]            buf_out_data;
  logic                   echo_take;
  logic [2:0]             cls;

  // returns {known, echo, hold} from the bits seen so far
  function automatic logic [2:0] classify(
    input lrr_pkg::lrr_frame_type f,
    input logic [3:0]             cnt,
    input lrr_pkg::lrr_link_type  l,
    input logic                   aa
  );
    logic busy_data;
    logic ctl;
    logic addressed;
    logic [2:0] grp;
    // every linkage term kept, none left out
    busy_data = l.talker_active
              | l.serial_poll_active
              | l.dev_id_active
              | l.acc_id_active
              | l.talker_hold
              | l.talker_error
              | l.listener_active
              | l.not_ready_wait
              | l.ctl_active;
    ctl = l.ctl_active | l.ctl_standby;
    addressed = l.talker_addressed
              | l.talker_active
              | l.serial_poll_active
              | l.dev_id_active
              | l.acc_id_active
              | l.talker_hold
              | l.talker_error
              | l.talker_primary
              | l.listener_active
              | ctl;
    grp = f.data[lrr_pkg::GRP_HI:lrr_pkg::GRP_LO];
    classify = 3'h0;
    // data class known after first bit
    if (cnt >= lrr_pkg::CNT_DATA && !f.ctrl[lrr_pkg::C2_POS - lrr_pkg::C0_POS]) begin
      classify = {1'b1, !busy_data, busy_data};
    end else if (cnt >= lrr_pkg::CNT_IDENT && f.ctrl[1]) begin
      classify = {1'b1, !ctl, ctl};
    end else if (cnt >= lrr_pkg::CNT_CMD && f.ctrl == lrr_pkg::CTRL_CMD) begin
      // commands are always held, echoed too when not ours
      classify = {1'b1, !ctl, 1'b1};
    end else if (cnt >= lrr_pkg::CNT_GROUP && f.ctrl == lrr_pkg::CTRL_RDY) begin
      // each group term is an AND of its class and its linkages
      if (grp == lrr_pkg::GRP_ADDR_READY) begin
        classify = {1'b1, !addressed, addressed};
      end else if (grp == lrr_pkg::GRP_AUTO_ADDR) begin
        classify = {1'b1, aa, !aa};
      end else begin
        // other ready groups are held so the acceptor can sort them out
        classify = 3'h5;
      end
    end
  endfunction

  // attention and poll modifications applied at load time
  function automatic lrr_pkg::lrr_frame_type modify(
    input lrr_pkg::lrr_frame_type f,
    input logic                   is_echo,
    input logic                   attn,
    input logic                   pen,
    input logic [2:0]             psel,
    input logic                   pval
  );
    logic is_data;
    logic is_ident;
    modify = f;
    is_data  = !f.ctrl[2];
    is_ident = f.ctrl[2] & f.ctrl[1];
    // attention bit is the lowest control bit
    if (attn && (is_data || is_ident)) begin
      modify.ctrl[0] = 1'b1;
    end
    // poll response only on identify frames being retransmitted
    if (pen && is_echo && is_ident) begin
      modify.data[psel] = pval;
    end
  endfunction

  // one flag per state, true only while that state is held
  function automatic lrr_pkg::lrr_status_type state_flags(
    input lrr_pkg::lrr_rx_state_type rs,
    input lrr_pkg::lrr_tx_state_type ts
  );
    state_flags.rx_idle         = (rs == lrr_pkg::rx_idle);
    state_flags.rx_sync_decide  = (rs == lrr_pkg::rx_sync_decide);
    state_flags.rx_echo_handoff = (rs == lrr_pkg::rx_echo_handoff);
    state_flags.rx_hold_handoff = (rs == lrr_pkg::rx_hold_handoff);
    state_flags.tx_idle         = (ts == lrr_pkg::tx_idle);
    state_flags.tx_own_frame    = (ts == lrr_pkg::tx_own_frame);
    state_flags.tx_echo_frame   = (ts == lrr_pkg::tx_echo_frame);
    state_flags.tx_after_accept = (ts == lrr_pkg::tx_after_accept);
  endfunction

  assign cls = classify(s_q.rx_frm, s_q.rx_cnt, link, aa_echo);
  // transmitter takes the echo only once the whole frame is in
  assign echo_take = (s_q.rx_st == lrr_pkg::rx_echo_handoff)
                   && (s_q.rx_cnt == lrr_pkg::CNT_FULL)
                   && (s_q.tx_st == lrr_pkg::tx_idle);

  always_comb begin
    s_d = s_q;
    s_d.tx_done   = 1'b0;
    s_d.own_taken = 1'b0;
    s_d.acc_taken = 1'b0;
    buf_in_valid  = 1'b0;

    // bits land at their frame position as they arrive
    if (s_q.rx_st != lrr_pkg::rx_idle && rx_bit_valid
        && s_q.rx_cnt != lrr_pkg::CNT_FULL) begin
      s_d.rx_frm[lrr_pkg::CNT_LAST - s_q.rx_cnt] = rx_bit;
      s_d.rx_cnt = s_q.rx_cnt + 4'h1;
    end

    case (s_q.tx_st)
      lrr_pkg::tx_idle: begin
        // echo first, and no local frame is started while an echo handoff waits
        if (echo_take) begin
          s_d.tx_st = lrr_pkg::tx_echo_frame;
          s_d.tx_sh = modify(s_q.rx_frm, 1'b1, attention_bit, poll_en, poll_sel, poll_val);
        end else if (s_q.rx_st != lrr_pkg::rx_echo_handoff && acc_valid) begin
          s_d.tx_st = lrr_pkg::tx_after_accept;
          s_d.tx_sh = modify(acc_frame, 1'b0, attention_bit, poll_en, poll_sel, poll_val);
          s_d.acc_taken = 1'b1;
        end else if (s_q.rx_st != lrr_pkg::rx_echo_handoff && own_valid) begin
          s_d.tx_st = lrr_pkg::tx_own_frame;
          s_d.tx_sh = modify(own_frame, 1'b0, attention_bit, poll_en, poll_sel, poll_val);
          s_d.own_taken = 1'b1;
        end
        // first bit out is C2, flagged as sync
        if (s_d.tx_st != lrr_pkg::tx_idle) begin
          s_d.tx_cnt   = lrr_pkg::CNT_ZERO;
          s_d.tx_valid = 1'b1;
          s_d.tx_bit   = s_d.tx_sh[lrr_pkg::C2_POS];
          s_d.tx_sync  = 1'b1;
        end
      end
      lrr_pkg::tx_own_frame, lrr_pkg::tx_echo_frame, lrr_pkg::tx_after_accept: begin
        // stays in its send state while the encoder stalls
        if (s_q.tx_valid && tx_bit_ready) begin
          if (s_q.tx_cnt == lrr_pkg::CNT_LAST) begin
            // whole frame out, back to idle
            s_d.tx_st    = lrr_pkg::tx_idle;
            s_d.tx_valid = 1'b0;
            s_d.tx_sync  = 1'b0;
            s_d.tx_done  = 1'b1;
          end else begin
            // next bit read off the old shifter, no extra stage per bit
            s_d.tx_sh   = {s_q.tx_sh[9:0], 1'b0};
            s_d.tx_bit  = s_q.tx_sh[9];
            s_d.tx_cnt  = s_q.tx_cnt + 4'h1;
            s_d.tx_sync = 1'b0;
          end
        end
      end
      default: begin
        s_d.tx_st = lrr_pkg::tx_idle;
      end
    endcase

    case (s_q.rx_st)
      lrr_pkg::rx_idle: begin
        // only a valid sync bit starts a frame
        if (rx_bit_valid && rx_sync) begin
          s_d.rx_st  = lrr_pkg::rx_sync_decide;
          s_d.rx_frm = '0;
          s_d.rx_frm[lrr_pkg::C2_POS] = rx_bit;
          s_d.rx_cnt = lrr_pkg::CNT_DATA;
          s_d.rx_is_cmd = 1'b0;
        end
      end
      lrr_pkg::rx_sync_decide: begin
        // decide as soon as the class is known
        if (cls[2]) begin
          s_d.rx_is_cmd = cls[0];
          // echo handoff waits for a free transmitter
          if (cls[1] && s_d.tx_st == lrr_pkg::tx_idle) begin
            s_d.rx_st = lrr_pkg::rx_echo_handoff;
          end else if (!cls[1]) begin
            // frames for interpretation go to the acceptor
            s_d.rx_st = lrr_pkg::rx_hold_handoff;
          end
        end
      end
      lrr_pkg::rx_echo_handoff: begin
        if (echo_take) begin
          // commands continue to the acceptor after echo
          s_d.rx_st = s_q.rx_is_cmd ? lrr_pkg::rx_hold_handoff : lrr_pkg::rx_idle;
        end
      end
      lrr_pkg::rx_hold_handoff: begin
        // a full buffer keeps us here; later frames are dropped meanwhile
        // offer the completed frame to the acceptor path
        if (s_q.rx_cnt == lrr_pkg::CNT_FULL) begin
          buf_in_valid = 1'b1;
          // acceptance returns the receiver to idle
          if (buf_in_ready) begin
            s_d.rx_st = lrr_pkg::rx_idle;
          end
        end
      end
      default: begin
        s_d.rx_st = lrr_pkg::rx_idle;
      end
    endcase

    // state flags track the states the registers will hold
    s_d.stat = state_flags(s_d.rx_st, s_d.tx_st);
  end

  // reset is the one transition taken from every state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{
        rx_st:     lrr_pkg::rx_idle,
        rx_frm:    '0,
        rx_cnt:    lrr_pkg::CNT_ZERO,
        rx_is_cmd: 1'b0,
        tx_st:     lrr_pkg::tx_idle,
        tx_sh:     '0,
        tx_cnt:    lrr_pkg::CNT_ZERO,
        tx_valid:  1'b0,
        tx_bit:    1'b0,
        tx_sync:   1'b0,
        tx_done:   1'b0,
        own_taken: 1'b0,
        acc_taken: 1'b0,
        stat:      '{rx_idle: 1'b1, tx_idle: 1'b1, default: 1'b0}
      };
    end else begin
      s_q <= s_d;
    end
  end

  // a stalled acceptor backs up into the hold handoff; frames arriving meanwhile are dropped
  lrr_pair_buffer #(
    .WIDTH(lrr_pkg::FRAME_BITS)
  ) u_hold_buf (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .in_valid (buf_in_valid),
    .in_data  (s_q.rx_frm),
    .in_ready (buf_in_ready),
    .out_valid(hold_valid),
    .out_data (buf_out_data),
    .out_ready(hold_ready)
  );

  assign hold_frame   = buf_out_data;
  assign own_taken    = s_q.own_taken;
  assign acc_taken    = s_q.acc_taken;
  assign tx_bit       = s_q.tx_bit;
  assign tx_bit_valid = s_q.tx_valid;
  assign tx_sync      = s_q.tx_sync;
  assign tx_done      = s_q.tx_done;
  assign status       = s_q.stat;

endmodule // lrr_loop_node

//--- core/lrr_pair_buffer.sv
`timescale 1ns/1ps
module lrr_pair_buffer #(
  parameter int unsigned WIDTH = 11
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  typedef struct packed {
    logic [WIDTH-1:0] d1;
    logic [WIDTH-1:0] d0;
    logic             v1;
    logic             v0;
    logic             rdy;
  } lrr_buf_state_type;

  lrr_buf_state_type s_q;
  lrr_buf_state_type s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.v0 && out_ready) begin
      s_d.d0 = s_q.d1;
      s_d.v0 = s_q.v1;
      s_d.v1 = 1'b0;
    end
    // ready is registered, so a full pair refuses even while draining
    if (s_q.rdy && in_valid) begin
      if (!s_d.v0) begin
        s_d.d0 = in_data;
        s_d.v0 = 1'b1;
      end else begin
        s_d.d1 = in_data;
        s_d.v1 = 1'b1;
      end
    end
    s_d.rdy = !s_d.v1;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{d1: '0, d0: '0, v1: 1'b0, v0: 1'b0, rdy: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready  = s_q.rdy;
  assign out_valid = s_q.v0;
  assign out_data  = s_q.d0;

endmodule // lrr_pair_buffer

//--- core/lrr_pkg.sv
package lrr_pkg;

  // frame layout: C2 C1 C0 then D7..D0, first bit on the wire is C2
  localparam int unsigned FRAME_BITS = 11;
  localparam int unsigned C2_POS     = 10;
  localparam int unsigned C1_POS     = 9;
  localparam int unsigned C0_POS     = 8;
  localparam int unsigned GRP_HI     = 7;
  localparam int unsigned GRP_LO     = 5;

  // bit counts: zero, the counts at which a class can be told apart, last and full
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] CNT_DATA  = 4'h1;
  localparam logic [3:0] CNT_IDENT = 4'h2;
  localparam logic [3:0] CNT_CMD   = 4'h3;
  localparam logic [3:0] CNT_GROUP = 4'h6;
  localparam logic [3:0] CNT_FULL  = 4'hb;
  localparam logic [3:0] CNT_LAST  = 4'ha;

  // control field codes
  localparam logic [2:0] CTRL_CMD = 3'h4;
  localparam logic [2:0] CTRL_RDY = 3'h5;

  // ready-class group codes in D7..D5
  localparam logic [2:0] GRP_ADDR_READY = 3'h2;
  localparam logic [2:0] GRP_AUTO_ADDR  = 3'h4;

  typedef enum logic [1:0] {
    rx_idle         = 2'h0,
    rx_sync_decide  = 2'h1,
    rx_echo_handoff = 2'h3,
    rx_hold_handoff = 2'h2
  } lrr_rx_state_type;

  typedef enum logic [1:0] {
    tx_idle         = 2'h0,
    tx_own_frame    = 2'h1,
    tx_echo_frame   = 2'h3,
    tx_after_accept = 2'h2
  } lrr_tx_state_type;

  typedef struct packed {
    logic [2:0] ctrl;
    logic [7:0] data;
  } lrr_frame_type;

  // state linkages from talker, listener, controller and addressing logic
  typedef struct packed {
    logic talker_active;
    logic serial_poll_active;
    logic dev_id_active;
    logic acc_id_active;
    logic talker_hold;
    logic talker_error;
    logic talker_primary;
    logic talker_addressed;
    logic listener_active;
    logic not_ready_wait;
    logic ctl_active;
    logic ctl_standby;
  } lrr_link_type;

  typedef struct packed {
    logic rx_idle;
    logic rx_sync_decide;
    logic rx_echo_handoff;
    logic rx_hold_handoff;
    logic tx_idle;
    logic tx_own_frame;
    logic tx_echo_frame;
    logic tx_after_accept;
  } lrr_status_type;

endpackage

//--- tb/lrr_far_node.sv
`timescale 1ns/1ps
module lrr_far_node (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              tx_bit,
  input  wire logic              tx_bit_valid,
  input  wire logic              tx_sync,
  input  wire logic              stall,
  output logic                   tx_bit_ready,
  output lrr_pkg::lrr_frame_type got_frame,
  output logic [7:0]             got_cnt
);
  logic [10:0] sh_q;
  logic [3:0]  n_q;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_bit_ready <= 1'b0;
      sh_q <= 11'h000;
      n_q <= 4'h0;
      got_cnt <= 8'h00;
      got_frame <= 11'h000;
    end else begin
      // slow neighbour while stall is set: ready only every other cycle
      tx_bit_ready <= stall ? ~tx_bit_ready : 1'b1;
      // first bit is sync, msb first
      if (tx_bit_valid && tx_bit_ready) begin
        sh_q <= {sh_q[9:0], tx_bit};
        n_q <= tx_sync ? 4'h1 : n_q + 4'h1;
        if (!tx_sync && n_q == 4'ha) begin
          got_frame <= {sh_q[9:0], tx_bit};
          got_cnt <= got_cnt + 8'h01;
        end
      end
    end
  end
endmodule // lrr_far_node

//--- tb/lrr_loop_node_assertions.sv
`timescale 1ns/1ps
module lrr_loop_node_assertions (
  input wire logic                    ref_clk,
  input wire logic                    reset_n,
  input wire logic                    rx_bit_valid,
  input wire logic                    rx_sync,
  input wire logic                    hold_valid,
  input wire logic                    hold_ready,
  input wire lrr_pkg::lrr_frame_type  hold_frame,
  input wire logic                    own_taken,
  input wire logic                    acc_taken,
  input wire logic                    tx_bit,
  input wire logic                    tx_bit_valid,
  input wire logic                    tx_bit_ready,
  input wire logic                    tx_sync,
  input wire logic                    tx_done,
  input wire lrr_pkg::lrr_status_type status
);
  logic [3:0] sent_q;
  logic [3:0] sent_d;

  always_comb begin
    sent_d = tx_done ? 4'h0 : sent_q + {3'h0, tx_bit_valid & tx_bit_ready};
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sent_q <= 4'h0;
    end else begin
      sent_q <= sent_d;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_reset_idle: assert property ($rose(reset_n) |-> status == 8'h88)
    else $error("not idle after reset");
  a_idle_stays: assert property (status.rx_idle && !(rx_bit_valid && rx_sync)
    |=> status.rx_idle) else $error("receiver left idle without sync");
  a_sync_decide: assert property (status.rx_idle && rx_bit_valid && rx_sync
    |=> status.rx_sync_decide) else $error("sync not taken");
  a_start_sync: assert property ($rose(tx_bit_valid) |-> tx_sync && !status.tx_idle)
    else $error("frame start without sync");
  a_done_count: assert property (tx_done |-> sent_q == 4'hb && status.tx_idle
    && !tx_bit_valid) else $error("frame length wrong");
  a_bit_stall: assert property (tx_bit_valid && !tx_bit_ready
    |=> tx_bit_valid && $stable(tx_bit)) else $error("bit changed while stalled");
  a_hold_stall: assert property (hold_valid && !hold_ready
    |=> hold_valid && $stable(hold_frame)) else $error("held frame lost");
  a_echo_first: assert property (status.rx_echo_handoff |=> !own_taken && !acc_taken)
    else $error("offer taken over echo");
  a_echo_tx_idle: assert property (status.rx_echo_handoff |-> status.tx_idle)
    else $error("echo handoff with busy transmitter");
  a_taken_state: assert property (own_taken || acc_taken |-> tx_sync
    && (own_taken ? status.tx_own_frame : status.tx_after_accept))
    else $error("taken pulse in wrong state");

  c_echo: cover property (status.tx_echo_frame && tx_done);
  c_hold: cover property (hold_valid && hold_ready);
  c_own: cover property (own_taken);
  c_acc: cover property (acc_taken);
endmodule // lrr_loop_node_assertions

bind lrr_loop_node lrr_loop_node_assertions i_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .rx_bit_valid(rx_bit_valid), .rx_sync(rx_sync),
  .hold_valid(hold_valid), .hold_ready(hold_ready), .hold_frame(hold_frame),
  .own_taken(own_taken), .acc_taken(acc_taken), .tx_bit(tx_bit),
  .tx_bit_valid(tx_bit_valid), .tx_bit_ready(tx_bit_ready), .tx_sync(tx_sync),
  .tx_done(tx_done), .status(status)
);

//--- tb/lrr_loop_node_bench.sv
`timescale 1ns/1ps
module lrr_loop_node_bench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic rx_bit_valid = 1'b0;
  logic rx_bit = 1'b0;
  logic rx_sync = 1'b0;
  lrr_pkg::lrr_link_type link = 12'h000;
  logic own_valid = 1'b0;
  lrr_pkg::lrr_frame_type own_frame = 11'h000;
  logic acc_valid = 1'b0;
  lrr_pkg::lrr_frame_type acc_frame = 11'h000;
  logic attention_bit = 1'b0;
  logic poll_en = 1'b0;
  logic [2:0] poll_sel = 3'h0;
  logic poll_val = 1'b0;
  logic hold_ready = 1'b0;
  logic stall = 1'b0;
  logic aa_echo = 1'b0;
  logic tx_bit_ready, hold_valid, own_taken, acc_taken, tx_bit, tx_bit_valid, tx_sync, tx_done;
  lrr_pkg::lrr_frame_type hold_frame, got_frame;
  lrr_pkg::lrr_status_type status;
  logic [7:0] got_cnt;
  logic [7:0] want = 8'h00;
  int err_count = 0;
  int checked = 0;

  lrr_loop_node i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .rx_sync(rx_sync), .link(link), .aa_echo(aa_echo), .own_valid(own_valid),
    .own_frame(own_frame), .acc_valid(acc_valid), .acc_frame(acc_frame),
    .attention_bit(attention_bit), .poll_en(poll_en), .poll_sel(poll_sel),
    .poll_val(poll_val), .hold_ready(hold_ready), .tx_bit_ready(tx_bit_ready),
    .hold_valid(hold_valid), .hold_frame(hold_frame), .own_taken(own_taken),
    .acc_taken(acc_taken), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
    .tx_sync(tx_sync), .tx_done(tx_done), .status(status)
  );

  lrr_far_node i_far (
    .ref_clk(ref_clk), .reset_n(reset_n), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
    .tx_sync(tx_sync), .stall(stall), .tx_bit_ready(tx_bit_ready),
    .got_frame(got_frame), .got_cnt(got_cnt)
  );

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic tick;
    @(posedge ref_clk);
    #5;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic logic seen_it(input logic [1:0] s);
    case (s)
      2'h0: seen_it = hold_valid;
      2'h1: seen_it = own_taken;
      2'h2: seen_it = acc_taken;
      default: seen_it = (got_cnt === want);
    endcase
  endfunction

  task automatic await(input logic [1:0] s);
    int k;
    for (k = 0; k < 400 && seen_it(s) !== 1'b1; k++) begin
      tick;
    end
    if (seen_it(s) !== 1'b1) begin
      chk(16'h0000, 16'h0001);
      conclude;
    end
  endtask

  task automatic expect_out(input lrr_pkg::lrr_frame_type exp);
    want = want + 8'h01;
    await(2'h3);
    chk({5'h00, got_frame}, {5'h00, exp});
  endtask

  // two idle cycles let the receiver finish its handoff
  task automatic send(input lrr_pkg::lrr_frame_type f);
    int i;
    for (i = 10; i >= 0; i--) begin
      rx_bit_valid = 1'b1;
      rx_sync = (i == 10);
      rx_bit = f[i];
      tick;
    end
    rx_bit_valid = 1'b0;
    rx_sync = 1'b0;
    repeat (2) tick;
  endtask

  task automatic t_reset;
    chk({8'h00, status}, 16'h0088);
    chk({11'h000, hold_valid, own_taken, acc_taken, tx_bit_valid, tx_done}, 16'h0000);
  endtask

  task automatic t_echo;
    lrr_pkg::lrr_frame_type fin[3] = '{11'h0a5, 11'h640, 11'h540};
    lrr_pkg::lrr_frame_type fout[3] = '{11'h1a5, 11'h748, 11'h540};
    int i;
    stall = 1'b1;
    attention_bit = 1'b1;
    poll_en = 1'b1;
    poll_sel = 3'h3;
    poll_val = 1'b1;
    for (i = 0; i < 3; i++) begin
      send(fin[i]);
      expect_out(fout[i]);
      tick;
      chk({8'h00, status}, 16'h0088);
      chk({15'h0000, hold_valid}, 16'h0000);
    end
    stall = 1'b0;
    attention_bit = 1'b0;
    poll_en = 1'b0;
  endtask

  task automatic t_cmd;
    send(11'h43f);
    expect_out(11'h43f);
    await(2'h0);
    chk({5'h00, hold_frame}, 16'h043f);
    hold_ready = 1'b1;
    tick;
    hold_ready = 1'b0;
    chk({15'h0000, hold_valid}, 16'h0000);
    chk({8'h00, status}, 16'h0088);
  endtask

  // third frame finds the buffer full and must wait, not vanish
  task automatic t_buffer;
    int i;
    link.listener_active = 1'b1;
    for (i = 1; i < 4; i++) begin
      send({3'h0, 8'(i)});
    end
    chk({12'h000, status[7:4]}, 16'h0001);
    chk({8'h00, got_cnt}, {8'h00, want});
    hold_ready = 1'b1;
    for (i = 1; i < 4; i++) begin
      await(2'h0);
      chk({5'h00, hold_frame}, 16'(i));
      tick;
    end
    hold_ready = 1'b0;
    link.listener_active = 1'b0;
    chk({15'h0000, hold_valid}, 16'h0000);
  endtask

  task automatic t_prio;
    own_frame = 11'h011;
    acc_frame = 11'h422;
    own_valid = 1'b1;
    acc_valid = 1'b1;
    await(2'h2);
    acc_valid = 1'b0;
    chk({15'h0000, own_taken}, 16'h0000);
    expect_out(11'h422);
    await(2'h1);
    own_valid = 1'b0;
    expect_out(11'h011);
  endtask

  // echo arrives while the transmitter is still busy with an own frame
  task automatic t_busy;
    own_frame = 11'h077;
    own_valid = 1'b1;
    await(2'h1);
    own_valid = 1'b0;
    stall = 1'b1;
    send(11'h0c3);
    expect_out(11'h077);
    expect_out(11'h0c3);
    stall = 1'b0;
  endtask

  // auto-address echo follows aa_echo; other ready groups and controller frames are held
  task automatic t_class;
    lrr_pkg::lrr_frame_type fin[4] = '{11'h581, 11'h500, 11'h640, 11'h43f};
    int i;
    aa_echo = 1'b1;
    send(fin[0]);
    expect_out(fin[0]);
    chk({15'h0000, hold_valid}, 16'h0000);
    aa_echo = 1'b0;
    link.ctl_active = 1'b1;
    for (i = 0; i < 4; i++) begin
      send(fin[i]);
      await(2'h0);
      chk({5'h00, hold_frame}, {5'h00, fin[i]});
      hold_ready = 1'b1;
      tick;
      hold_ready = 1'b0;
    end
    // a wrongly echoed last frame would still be on the wire
    repeat (12) tick;
    chk({8'h00, got_cnt}, {8'h00, want});
    link.ctl_active = 1'b0;
  endtask

  task automatic t_rerun;
    own_valid = 1'b1;
    repeat (4) tick;
    reset_n = 1'b0;
    own_valid = 1'b0;
    want = 8'h00;
    tick;
    reset_n = 1'b1;
    tick;
    t_reset();
  endtask

  initial begin
    repeat (2) tick;
    reset_n = 1'b1;
    tick;
    t_reset();
    t_echo();
    t_cmd();
    t_buffer();
    t_prio();
    t_busy();
    t_class();
    t_rerun();
    conclude();
  end
endmodule // lrr_loop_node_bench
